// ==== shared/dqsosc_pkg.sv ====
package dqsosc_pkg;
  // Multi-purpose command operand codes
  localparam logic [6:0] MPC_OSC_START   = 7'h4B;
  localparam logic [6:0] MPC_OSC_STOP    = 7'h4D;
  localparam int         TRAIN_SEL_BIT   = 6;
  // Mode register indices
  localparam logic [7:0] MR_COUNT_LOW    = 8'h12;
  localparam logic [7:0] MR_COUNT_HIGH   = 8'h13;
  localparam logic [7:0] MR_AUTOSTOP_CFG = 8'h17;
  // Reset values
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
  // Auto-stop clocks per step of the configuration value
  localparam int          AUTOSTOP_UNIT  = 16;
  // Timing
  localparam int CLK_PERIOD_PS           = 25000;
  localparam int READOUT_MIN_PS          = 40000;
  localparam int READOUT_MIN_NCK         = 8;
  localparam int READOUT_PS_CYC          = (READOUT_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READOUT_CYC             =
    (READOUT_PS_CYC > READOUT_MIN_NCK) ? READOUT_PS_CYC : READOUT_MIN_NCK;
  localparam int RUN_MIN_PS              = 200000;
  localparam int RUN_MIN_CYC             = (RUN_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Longest run that cannot overflow the 16-bit count
  localparam int STROBE_MIN_PS           = 200;
  localparam int RUN_MAX_PS              = 65536 * STROBE_MIN_PS;
  localparam int RUN_MAX_CYC             = RUN_MAX_PS / CLK_PERIOD_PS;
  // AXI4-Lite register offsets of the controller
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_STATUS      = 8'h04;
  localparam logic [7:0] REG_RESULT      = 8'h08;
  localparam logic [7:0] REG_AUTOSTOP    = 8'h0C;
  localparam logic [7:0] REG_RUNTIME     = 8'h10;
  localparam logic [15:0] RUNTIME_RESET  = 16'h0010;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage : dqsosc_pkg

// ==== shared/dqsosc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface dqsosc_if;
  logic       mpc_valid;
  logic [6:0] mpc_op;
  logic       mrw_valid;
  logic       mrr_valid;
  logic [7:0] mr_addr;
  logic [7:0] mr_wdata;
  logic       mrr_ack;
  logic [7:0] mrr_data;
  modport device (
    input  mpc_valid,
    input  mpc_op,
    input  mrw_valid,
    input  mrr_valid,
    input  mr_addr,
    input  mr_wdata,
    output mrr_ack,
    output mrr_data
  );
  modport ctrl (
    output mpc_valid,
    output mpc_op,
    output mrw_valid,
    output mrr_valid,
    output mr_addr,
    output mr_wdata,
    input  mrr_ack,
    input  mrr_data
  );
endinterface : dqsosc_if
`default_nettype wire

// ==== logic/dqsosc_device.sv ====
// How it works
// - Start command launches ring oscillator count.
// - Stop command halts counter unless auto-stop.
// - Auto-stop ends run after 16 clocks per programmed step.
// - Controller never stops while auto-stop set.
// - Any stop copies count into result.
// - Result split low byte, high byte.
// - Each stop overwrites both result registers.
// - Counter saturates at maximum, never wraps.
// - Controller flags maximum value as overflow.
// - Controller sets run time start-to-stop.
// - Controller runs at least 200 ns.
// - Controller limits manual run to avoid overflow.
// - Controller waits readout delay before reading.
// - No restart before readout delay elapses.
// - Top operand bit selects NOP or training.
// - Start and stop commands stand alone.
`timescale 1ns/1ps
`default_nettype none
module dqsosc_device (
  input  wire logic   sys_clk,
  input  wire logic   arst_n,
  input  wire logic   ring_tick,
  dqsosc_if.device    bus,
  output logic        osc_running
);
  ////////////////////////////////////////////////////////////////////////////
  logic        run_q,   run_d;
  logic [15:0] cnt_q,   cnt_d;
  logic [15:0] res_q,   res_d;
  logic [7:0]  cfg_q,   cfg_d;
  logic [15:0] auto_q,  auto_d;
  logic        ack_q,   ack_d;
  logic [7:0]  rd_q,    rd_d;
  logic        train_cmd;
  logic        stop_now;

  always_comb begin
    train_cmd = bus.mpc_valid && bus.mpc_op[dqsosc_pkg::TRAIN_SEL_BIT];
    run_d  = run_q;
    cnt_d  = cnt_q;
    res_d  = res_q;
    cfg_d  = cfg_q;
    auto_d = auto_q;
    stop_now = 1'b0;
    if (bus.mrw_valid && bus.mr_addr == dqsosc_pkg::MR_AUTOSTOP_CFG) begin
      cfg_d = bus.mr_wdata;
    end
    if (run_q) begin
      if (ring_tick && cnt_q != dqsosc_pkg::COUNT_MAX) begin
        cnt_d = cnt_q + 16'h0001;
      end
      if (cfg_q != dqsosc_pkg::CFG_RESET) begin
        auto_d = auto_q - 16'h0001;
        if (auto_q == 16'h0001) begin
          stop_now = 1'b1;
        end
      end
      // stop by command, ignored under auto-stop
      if (train_cmd && bus.mpc_op == dqsosc_pkg::MPC_OSC_STOP
          && cfg_q == dqsosc_pkg::CFG_RESET) begin
        stop_now = 1'b1;
      end
    end
    // capture on stop, overwrite both bytes
    if (stop_now) begin
      run_d = 1'b0;
      res_d = cnt_d;
    end
    if (train_cmd && bus.mpc_op == dqsosc_pkg::MPC_OSC_START) begin
      run_d  = 1'b1;
      cnt_d  = dqsosc_pkg::COUNT_RESET;
      auto_d = 16'(cfg_q * dqsosc_pkg::AUTOSTOP_UNIT);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q  <= 1'b0;
      cnt_q  <= dqsosc_pkg::COUNT_RESET;
      res_q  <= dqsosc_pkg::COUNT_RESET;
      cfg_q  <= dqsosc_pkg::CFG_RESET;
      auto_q <= 16'h0000;
    end else begin
      run_q  <= run_d;
      cnt_q  <= cnt_d;
      res_q  <= res_d;
      cfg_q  <= cfg_d;
      auto_q <= auto_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ack_d = bus.mrr_valid;
    rd_d  = 8'h00;
    case (bus.mr_addr)
      dqsosc_pkg::MR_COUNT_LOW:    rd_d = res_q[7:0];
      dqsosc_pkg::MR_COUNT_HIGH:   rd_d = res_q[15:8];
      dqsosc_pkg::MR_AUTOSTOP_CFG: rd_d = cfg_q;
      default:                     rd_d = 8'h00;
    endcase
    if (!bus.mrr_valid) begin
      rd_d = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      rd_q  <= 8'h00;
    end else begin
      ack_q <= ack_d;
      rd_q  <= rd_d;
    end
  end

  assign bus.mrr_ack  = ack_q;
  assign bus.mrr_data = rd_q;
  assign osc_running  = run_q;
endmodule : dqsosc_device
`default_nettype wire

// ==== logic/dqsosc_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module dqsosc_ctrl (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  dqsosc_if.ctrl            mem
);
  typedef enum logic [2:0] {
    DQSC_IDLE, DQSC_CFG, DQSC_RUN, DQSC_WAIT, DQSC_RD_LO, DQSC_RD_HI
  } dqsc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  dqsc_state_t st_q, st_d;
  logic [15:0] tmr_q, tmr_d;
  logic [15:0] res_q, res_d;
  logic [7:0]  auto_q, auto_d;
  logic [15:0] rt_q, rt_d;
  logic        go_q, go_d;
  logic        done_q, done_d;
  logic        ovf_q, ovf_d;
  logic        mpc_v_q, mpc_v_d;
  logic [6:0]  op_q, op_d;
  logic        mrw_q, mrw_d, mrr_q, mrr_d;
  logic [7:0]  ma_q, ma_d, mw_q, mw_d;
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, ar_q, ar_d, r_q, r_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        busy;

  assign busy = (st_q != DQSC_IDLE);

  always_comb begin
    aw_d = aw_q; w_d = w_q; b_d = b_q; ar_d = ar_q; r_d = r_q;
    awa_d = awa_q; wd_d = wd_q; rd_d = rd_q; bresp_d = bresp_q; rresp_d = rresp_q;
    auto_d = auto_q; rt_d = rt_q; go_d = 1'b0; done_d = done_q;
    if (s_axi_awvalid && !aw_q && !b_q) begin
      aw_d = 1'b1; awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !b_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    end
    if (aw_q && w_q) begin
      aw_d = 1'b0; w_d = 1'b0; b_d = 1'b1; bresp_d = dqsosc_pkg::RESP_OKAY;
      case (awa_q)
        dqsosc_pkg::REG_CTRL: begin
          if (wd_q[0] && !busy) go_d = 1'b1;
          if (wd_q[1]) done_d = 1'b0;
        end
        dqsosc_pkg::REG_AUTOSTOP: if (!busy) auto_d = wd_q[7:0];
        dqsosc_pkg::REG_RUNTIME:  rt_d = wd_q[15:0];
        default: bresp_d = dqsosc_pkg::RESP_SLVERR;
      endcase
    end
    if (b_q && s_axi_bready) b_d = 1'b0;
    if (s_axi_arvalid && !ar_q && !r_q) begin
      ar_d = 1'b1; rresp_d = dqsosc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        dqsosc_pkg::REG_CTRL:     rd_d = 32'h0000_0000;
        dqsosc_pkg::REG_STATUS:   rd_d = {29'h0, ovf_q, done_q, busy};
        dqsosc_pkg::REG_RESULT:   rd_d = {16'h0000, res_q};
        dqsosc_pkg::REG_AUTOSTOP: rd_d = {24'h000000, auto_q};
        dqsosc_pkg::REG_RUNTIME:  rd_d = {16'h0000, rt_q};
        default: begin
          rd_d = 32'h0000_0000; rresp_d = dqsosc_pkg::RESP_SLVERR;
        end
      endcase
    end else begin
      ar_d = 1'b0;
    end
    // Read data only after the address handshake
    if (ar_q && s_axi_arvalid) r_d = 1'b1;
    if (r_q && s_axi_rready) r_d = 1'b0;
    if (st_q == DQSC_RD_HI && mem.mrr_ack) done_d = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q; tmr_d = tmr_q; res_d = res_q; ovf_d = ovf_q;
    mpc_v_d = 1'b0; op_d = op_q; mrw_d = 1'b0; mrr_d = 1'b0; ma_d = ma_q; mw_d = mw_q;
    case (st_q)
      DQSC_IDLE: if (go_q) begin
        mrw_d = 1'b1; ma_d = dqsosc_pkg::MR_AUTOSTOP_CFG; mw_d = auto_q;
        st_d = DQSC_CFG;
      end
      DQSC_CFG: begin
        mpc_v_d = 1'b1; op_d = dqsosc_pkg::MPC_OSC_START;
        tmr_d = (auto_q != 8'h00)
              ? 16'(auto_q * dqsosc_pkg::AUTOSTOP_UNIT + 2)
              : ((rt_q < 16'(dqsosc_pkg::RUN_MIN_CYC)) ? 16'(dqsosc_pkg::RUN_MIN_CYC)
              : ((rt_q > 16'(dqsosc_pkg::RUN_MAX_CYC)) ? 16'(dqsosc_pkg::RUN_MAX_CYC) : rt_q));
        st_d = DQSC_RUN;
      end
      DQSC_RUN: begin
        tmr_d = tmr_q - 16'h0001;
        if (tmr_q == 16'h0001) begin
          if (auto_q == 8'h00) begin
            mpc_v_d = 1'b1; op_d = dqsosc_pkg::MPC_OSC_STOP;
          end
          tmr_d = 16'(dqsosc_pkg::READOUT_CYC);
          st_d = DQSC_WAIT;
        end
      end
      DQSC_WAIT: begin
        tmr_d = tmr_q - 16'h0001;
        if (tmr_q == 16'h0001) begin
          mrr_d = 1'b1; ma_d = dqsosc_pkg::MR_COUNT_LOW; st_d = DQSC_RD_LO;
        end
      end
      DQSC_RD_LO: if (mem.mrr_ack) begin
        res_d[7:0] = mem.mrr_data;
        mrr_d = 1'b1; ma_d = dqsosc_pkg::MR_COUNT_HIGH; st_d = DQSC_RD_HI;
      end
      DQSC_RD_HI: if (mem.mrr_ack) begin
        res_d[15:8] = mem.mrr_data;
        ovf_d = ({mem.mrr_data, res_q[7:0]} == dqsosc_pkg::COUNT_MAX);
        st_d = DQSC_IDLE;
      end
      default: st_d = DQSC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= DQSC_IDLE; tmr_q <= 16'h0000; res_q <= dqsosc_pkg::COUNT_RESET;
      ovf_q <= 1'b0; mpc_v_q <= 1'b0; op_q <= 7'h00; mrw_q <= 1'b0; mrr_q <= 1'b0;
      ma_q <= 8'h00; mw_q <= 8'h00; auto_q <= dqsosc_pkg::CFG_RESET;
      rt_q <= dqsosc_pkg::RUNTIME_RESET; go_q <= 1'b0; done_q <= 1'b0;
      aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; ar_q <= 1'b0; r_q <= 1'b0;
      awa_q <= 8'h00; wd_q <= 32'h0000_0000; rd_q <= 32'h0000_0000;
      bresp_q <= 2'h0; rresp_q <= 2'h0;
    end else begin
      st_q <= st_d; tmr_q <= tmr_d; res_q <= res_d; ovf_q <= ovf_d;
      mpc_v_q <= mpc_v_d; op_q <= op_d; mrw_q <= mrw_d; mrr_q <= mrr_d;
      ma_q <= ma_d; mw_q <= mw_d; auto_q <= auto_d; rt_q <= rt_d;
      go_q <= go_d; done_q <= done_d;
      aw_q <= aw_d; w_q <= w_d; b_q <= b_d; ar_q <= ar_d; r_q <= r_d;
      awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d; bresp_q <= bresp_d; rresp_q <= rresp_d;
    end
  end

  assign s_axi_awready = aw_d && !aw_q;
  assign s_axi_wready  = w_d && !w_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ar_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rresp_q;
  assign mem.mpc_valid = mpc_v_q;
  assign mem.mpc_op    = op_q;
  assign mem.mrw_valid = mrw_q;
  assign mem.mrr_valid = mrr_q;
  assign mem.mr_addr   = ma_q;
  assign mem.mr_wdata  = mw_q;
endmodule : dqsosc_ctrl
`default_nettype wire

// ==== verification/dqsosc_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module dqsosc_properties (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       mpc_valid,
  input wire logic [6:0] mpc_op,
  input wire logic       mrw_valid,
  input wire logic       mrr_valid,
  input wire logic [7:0] mr_addr,
  input wire logic [7:0] mr_wdata,
  input wire logic       mrr_ack,
  input wire logic       osc_running
);
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic       st;
  logic       sp;
  logic [15:0] span_q;
  logic [15:0] span_d;
  assign st = mpc_valid && mpc_op == dqsosc_pkg::MPC_OSC_START;
  assign sp = mpc_valid && mpc_op == dqsosc_pkg::MPC_OSC_STOP;
  // Shadow of auto-stop setting
  always_comb begin
    cfg_d = cfg_q;
    if (mrw_valid && mr_addr == dqsosc_pkg::MR_AUTOSTOP_CFG) cfg_d = mr_wdata;
  end
  // Cycles since the last start command
  always_comb begin
    span_d = span_q;
    if (st) span_d = 16'h0001;
    else if (span_q != 16'hFFFF) span_d = span_q + 16'h0001;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q  <= dqsosc_pkg::CFG_RESET;
      span_q <= 16'h0000;
    end else begin
      cfg_q  <= cfg_d;
      span_q <= span_d;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  osc_start_a: assert property (st |=> osc_running) else $error("start missed");
  osc_halt_a: assert property (sp && cfg_q == 8'h00 |=> !osc_running) else $error("no halt");
  auto_stop_a: assert property (st && cfg_q == 8'h01 |=>
    osc_running [*8] ##[6:10] !osc_running) else $error("auto stop wrong");
  no_auto_stop_a: assert property (sp |-> cfg_q == 8'h00) else $error("stop in auto");
  readout_wait_a: assert property ($fell(osc_running) |-> !mrr_valid [*7])
    else $error("early readout");
  no_restart_a: assert property ($fell(osc_running) |-> !st [*7]) else $error("early start");
  run_floor_a: assert property (sp |-> span_q >= 16'(dqsosc_pkg::RUN_MIN_CYC))
    else $error("run too short");
  run_ceiling_a: assert property (sp |-> span_q <= 16'(dqsosc_pkg::RUN_MAX_CYC))
    else $error("run too long");
  train_op_a: assert property (mpc_valid |-> mpc_op[6]) else $error("nop issued");
  stand_alone_a: assert property (mpc_valid |=> !mpc_valid) else $error("no gap");
  mrr_resp_a: assert property (mrr_valid |=> mrr_ack) else $error("no read ack");
  ack_cause_a: assert property (mrr_ack |-> $past(mrr_valid)) else $error("stray ack");
  cover property (st && cfg_q != 8'h00);
  cover property (sp);
  cover property (mrr_ack);
endmodule : dqsosc_properties
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, arst_n, ring_tick, osc_running;
  logic [7:0] s_axi_awaddr, s_axi_araddr, lo_q, hi_q, rd_a;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int num_errors, comparisons;
  dqsosc_if bus();
  dqsosc_device u_dqsosc_device (.sys_clk, .arst_n, .ring_tick, .bus(bus), .osc_running);
  dqsosc_ctrl u_dqsosc_ctrl (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem(bus));
  dqsosc_properties u_dqsosc_properties (.sys_clk, .arst_n, .mpc_valid(bus.mpc_valid),
    .mpc_op(bus.mpc_op), .mrw_valid(bus.mrw_valid), .mrr_valid(bus.mrr_valid),
    .mr_addr(bus.mr_addr), .mr_wdata(bus.mr_wdata), .mrr_ack(bus.mrr_ack), .osc_running);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Capture of bytes read back
  always @(posedge sys_clk) begin
    if (bus.mrr_valid) rd_a <= bus.mr_addr;
    if (bus.mrr_ack && rd_a === dqsosc_pkg::MR_COUNT_LOW) lo_q <= bus.mrr_data;
    if (bus.mrr_ack && rd_a === dqsosc_pkg::MR_COUNT_HIGH) hi_q <= bus.mrr_data;
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (!got) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin r = s_axi_bresp; got = 1; end
    end
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    while (!got) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin d = s_axi_rdata; r = s_axi_rresp; got = 1; end
    end
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // One measurement with n ring ticks inside the run
  task run(input logic [15:0] rt, input logic [7:0] cfg, input int n);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(dqsosc_pkg::REG_AUTOSTOP, {24'h0, cfg}, r);
    axi_wr(dqsosc_pkg::REG_RUNTIME, {16'h0, rt}, r);
    fork
      axi_wr(dqsosc_pkg::REG_CTRL, 32'h1, r);
      begin
        do @(posedge sys_clk);
        while (!(bus.mpc_valid && bus.mpc_op === dqsosc_pkg::MPC_OSC_START));
        @(posedge sys_clk);
        ring_tick <= 1'b1;
        repeat (n) @(posedge sys_clk);
        ring_tick <= 1'b0;
      end
    join
    d = 32'h0;
    while (d[1] !== 1'b1) axi_rd(dqsosc_pkg::REG_STATUS, d, r);
    chk(d, 32'h2);
    axi_rd(dqsosc_pkg::REG_RESULT, d, r);
    chk(d, 32'(n));
    chk({16'h0, hi_q, lo_q}, 32'(n));
    axi_wr(dqsosc_pkg::REG_CTRL, 32'h2, r);
    axi_rd(dqsosc_pkg::REG_STATUS, d, r);
    chk(d, 32'h0);
    $display("Test run with %0d ticks ended", n);
  endtask : run
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(dqsosc_pkg::REG_RUNTIME, d, r);
    chk(d, {16'h0, dqsosc_pkg::RUNTIME_RESET});
    axi_rd(8'h14, d, r);
    chk({30'h0, r}, {30'h0, dqsosc_pkg::RESP_SLVERR});
    axi_wr(8'h18, 32'h5, r);
    chk({30'h0, r}, {30'h0, dqsosc_pkg::RESP_SLVERR});
    $display("Test registers ended");
  endtask : t_regs
  task t_manual;
    run(16'h0020, 8'h00, 5);
    run(16'h0200, 8'h00, 421);
    run(16'h0002, 8'h00, 5);
    run(16'hFFFF, 8'h00, 100);
  endtask : t_manual
  task t_auto;
    run(16'h0200, 8'h01, 3);
  endtask : t_auto
  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    {ring_tick, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {num_errors, comparisons} = '0;
    arst_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_manual();
    t_auto();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
